//--- hdl/pss_pkg.sv
package pss_pkg;

	// ----------------------------------------------------------------
	// clock and time base
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	// one time-base period equals one ramp step interval of 0.1 ms
	localparam int TB_PERIOD_US_X10 = 1;
	localparam int TB_PERIOD_PS = TB_PERIOD_US_X10 * 100_000_000;
	localparam int TB_PERIOD_CYC = TB_PERIOD_PS / CLK_PERIOD_PS;
	// low phase of the shared time-base line, a quarter period
	localparam int TB_LOW_CYC = TB_PERIOD_CYC / 4;

	// ----------------------------------------------------------------
	// deglitch filter on the unfiltered undervoltage comparator
	// ----------------------------------------------------------------
	localparam int UV_FILTER_US = 70;
	localparam int UV_FILTER_CYC = (UV_FILTER_US * 1_000_000) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// timing figures counted in time-base ticks (0.1 ms each)
	// ----------------------------------------------------------------
	localparam int RAMP_STEP_US = 100;
	localparam int RAMP_SKIP_US = 250;
	localparam int RISE_MAX_MS = 1300;
	localparam logic [15:0] RISE_MAX_TICKS = 16'(RISE_MAX_MS * 1000 / RAMP_STEP_US);
	localparam int SERVO_MS = 90;
	localparam logic [15:0] SERVO_TICKS = 16'(SERVO_MS * 1000 / RAMP_STEP_US);

	// ----------------------------------------------------------------
	// switching-mode configuration fields
	// ----------------------------------------------------------------
	localparam int MODE_CCM_BIT = 0;
	localparam int MODE_SERVO_EN_BIT = 6;

	// ----------------------------------------------------------------
	// reference DAC step size in nanovolts
	// ----------------------------------------------------------------
	localparam logic [20:0] DAC_LSB_HI_NV = 21'd1375000;
	localparam logic [20:0] DAC_LSB_LO_NV = 21'd687500;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [15:0] TARGET_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	// synchroniser contents after reset: the time-base line idles high (bit 4)
	localparam logic [7:0] SYNC_RST = 8'h10;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		PSS_HOLD    = 5'b00001,
		PSS_RELEASE = 5'b00010,
		PSS_DELAY   = 5'b00100,
		PSS_RAMP    = 5'b01000,
		PSS_ON      = 5'b10000
	} pss_state_t;

endpackage

//--- hdl/pss_power_up_soft_start_servo.sv
// What this block does
// - hold run line low until ready
// - shared run line releases when all ready
// - count turn-on delay after run release
// - fastest shared time base sets timing
// - step target from zero to set point
// - skip ramp when rise below 0.25ms
// - ramp step every 0.1ms
// - force discontinuous mode during rise ramp
// - gpio releases above undervoltage, selectable source
// - deglitch unfiltered comparator for 70us
// - servo enabled by mode bit 6
// - servo nudges dac every 90ms
// - servo step is one dac lsb
// - servo waits for turn-on limit unless zero
// - zero limit: ramp done, no uv, no oc
// - switch to programmed mode when servo permitted
// - nonzero limit: wait expiry, then no faults if response set, else no uv or no oc
// - clamp rise time to 1.3 seconds
`timescale 1ns/1ps
`default_nettype none

module pss_power_up_soft_start_servo
	import pss_pkg::*;
#(
	parameter int TB_PERIOD = TB_PERIOD_CYC,
	parameter int TB_LOW = TB_LOW_CYC,
	parameter int UV_FILTER = UV_FILTER_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic init_done,
	input wire logic vin_above_on,
	input wire logic run_line_i,
	output logic run_line_o,
	output logic run_line_oe,
	input wire logic share_clk_i,
	output logic share_clk_o,
	output logic share_clk_oe,
	input wire logic [15:0] turn_on_delay,
	input wire logic [15:0] ramp_rise_time,
	input wire logic [15:0] max_turn_on_time_limit,
	input wire logic max_turn_on_time_response,
	input wire logic [15:0] vout_set_point,
	input wire logic [7:0] switching_mode_config,
	input wire logic voltage_range_high,
	input wire logic uv_unfiltered,
	input wire logic uv_filtered,
	input wire logic output_overcurrent_fault,
	input wire logic reverse_current,
	input wire logic unfiltered_uv_propagate_select,
	input wire logic [15:0] adc_reading,
	output logic [15:0] ref_dac_code,
	output logic [20:0] servo_step_nv,
	output logic dcm_forced,
	output logic ccm_active,
	output logic bottom_gate_off,
	output logic servo_active,
	output logic gpio_o,
	output logic gpio_oe
);

	// ----------------------------------------------------------------
	// synchronisers for inputs from outside the clock domain
	// ----------------------------------------------------------------
	localparam int NSYNC = 8;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	assign async_in = {init_done, vin_above_on, run_line_i, share_clk_i, uv_unfiltered,
		uv_filtered, output_overcurrent_fault, reverse_current};

	// two flops per input, the first read only by the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	logic init_s, vin_s, run_s, tb_s, uvu_s, uvf_s, oc_s, rev_s;
	assign {init_s, vin_s, run_s, tb_s, uvu_s, uvf_s, oc_s, rev_s} = sync2_q;

	// ----------------------------------------------------------------
	// shared time base
	// ----------------------------------------------------------------
	logic tb_prev_q;
	logic [15:0] tb_cnt_q;
	logic tb_tick;
	logic tb_fall;
	assign tb_tick = tb_s & ~tb_prev_q;
	assign tb_fall = ~tb_s & tb_prev_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tb_prev_q <= 1'b1; // idle level, so no false tick after reset
		end else begin
			tb_prev_q <= tb_s;
		end
	end

	// a falling edge from any faster device restarts our period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tb_cnt_q <= COUNT_RST;
		end else if (tb_fall || tb_cnt_q == 16'(TB_PERIOD - 1)) begin
			tb_cnt_q <= COUNT_RST;
		end else begin
			tb_cnt_q <= tb_cnt_q + 16'h0001;
		end
	end

	// pull the line low at the start of each period, released before init
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			share_clk_oe <= 1'b0;
		end else begin
			share_clk_oe <= init_s && (tb_cnt_q < 16'(TB_LOW));
		end
	end
	assign share_clk_o = 1'b0;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	pss_state_t state_q;
	logic [15:0] tick_cnt_q;
	logic [15:0] limit_cnt_q;
	logic [15:0] rise_steps;
	logic ramp_skip;
	logic ready;
	logic step_done;

	assign ready = init_s & vin_s;
	// clamp to the longest allowed rise time
	assign rise_steps = (ramp_rise_time > RISE_MAX_TICKS) ? RISE_MAX_TICKS : ramp_rise_time;
	// rise time below the skip figure gives a direct jump
	assign ramp_skip = (32'(ramp_rise_time) * 32'(RAMP_STEP_US)) < 32'(RAMP_SKIP_US);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= PSS_HOLD;
			tick_cnt_q <= COUNT_RST;
		end else if (!ready) begin
			state_q <= PSS_HOLD;
			tick_cnt_q <= COUNT_RST;
		end else begin
			case (state_q)
				PSS_HOLD: begin
					state_q <= PSS_RELEASE;
				end
				PSS_RELEASE: begin
					// the wired line rises only once every device lets go
					if (run_s) begin
						state_q <= PSS_DELAY;
						tick_cnt_q <= COUNT_RST;
					end
				end
				PSS_DELAY: begin
					if (!run_s) begin
						state_q <= PSS_RELEASE;
					end else if (tick_cnt_q >= turn_on_delay) begin
						state_q <= PSS_RAMP;
						tick_cnt_q <= COUNT_RST;
					end else if (tb_tick) begin
						tick_cnt_q <= tick_cnt_q + 16'h0001;
					end
				end
				PSS_RAMP: begin
					if (!run_s) begin
						state_q <= PSS_RELEASE;
					end else if (ramp_skip || (step_done && tick_cnt_q >= rise_steps)) begin
						state_q <= PSS_ON;
					end else if (tb_tick) begin
						tick_cnt_q <= tick_cnt_q + 16'h0001;
					end
				end
				PSS_ON: begin
					if (!run_s) begin
						state_q <= PSS_RELEASE;
					end
				end
				default: begin
					state_q <= PSS_HOLD;
				end
			endcase
		end
	end

	// run line driven low while not ready
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_line_oe <= 1'b1;
		end else begin
			run_line_oe <= !ready || state_q == PSS_HOLD;
		end
	end
	assign run_line_o = 1'b0;

	// ----------------------------------------------------------------
	// ramp target: set point * step / steps by a serial divider
	// ----------------------------------------------------------------
	logic [31:0] num_q;
	logic [31:0] quo_q;
	logic [15:0] rem_q;
	logic [5:0] bit_q;
	logic div_busy_q;
	logic [15:0] last_step_q;
	logic [16:0] rem_try;
	assign rem_try = {rem_q, num_q[31]} - {1'b0, rise_steps};
	assign step_done = !div_busy_q && last_step_q == tick_cnt_q;

	// start a division whenever the step index moves on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			num_q <= '0;
			quo_q <= '0;
			rem_q <= '0;
			bit_q <= '0;
			div_busy_q <= 1'b0;
			last_step_q <= COUNT_RST;
		end else if (state_q != PSS_RAMP) begin
			// clear the quotient so a new ramp starts from zero, not the old set point
			quo_q <= '0;
			div_busy_q <= 1'b0;
			last_step_q <= COUNT_RST;
		end else if (!div_busy_q && last_step_q != tick_cnt_q && !ramp_skip) begin
			num_q <= 32'(vout_set_point) * 32'(tick_cnt_q);
			quo_q <= '0;
			rem_q <= '0;
			bit_q <= 6'd32;
			div_busy_q <= 1'b1;
			last_step_q <= tick_cnt_q;
		end else if (div_busy_q) begin
			if (!rem_try[16]) begin
				rem_q <= rem_try[15:0];
				quo_q <= {quo_q[30:0], 1'b1};
			end else begin
				rem_q <= {rem_q[14:0], num_q[31]};
				quo_q <= {quo_q[30:0], 1'b0};
			end
			num_q <= {num_q[30:0], 1'b0};
			bit_q <= bit_q - 6'd1;
			if (bit_q == 6'd1) begin
				div_busy_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// servo permission and turn-on limit timer
	// ----------------------------------------------------------------
	logic limit_done;
	logic uv_ok;
	logic servo_ok;
	assign limit_done = limit_cnt_q >= max_turn_on_time_limit;
	assign uv_ok = !uvf_s;

	// counts ticks from the start of the ramp
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			limit_cnt_q <= COUNT_RST;
		end else if (state_q != PSS_RAMP && state_q != PSS_ON) begin
			limit_cnt_q <= COUNT_RST;
		end else if (tb_tick && !limit_done) begin
			limit_cnt_q <= limit_cnt_q + 16'h0001;
		end
	end

	always_comb begin
		if (state_q != PSS_ON) begin
			servo_ok = 1'b0;
		end else if (max_turn_on_time_limit == 16'h0000) begin
			servo_ok = uv_ok && !oc_s;
		end else if (max_turn_on_time_response) begin
			servo_ok = limit_done && uv_ok && !oc_s;
		end else begin
			servo_ok = limit_done && (uv_ok || !oc_s);
		end
	end

	logic permit_q;
	// permission latches until the output is turned off again
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			permit_q <= 1'b0;
		end else if (state_q != PSS_ON) begin
			permit_q <= 1'b0;
		end else if (servo_ok) begin
			permit_q <= 1'b1;
		end
	end

	// mode outputs: discontinuous until permitted
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dcm_forced <= 1'b1;
			ccm_active <= 1'b0;
			bottom_gate_off <= 1'b0;
		end else begin
			dcm_forced <= !permit_q;
			ccm_active <= permit_q && switching_mode_config[MODE_CCM_BIT];
			bottom_gate_off <= rev_s && !(permit_q && switching_mode_config[MODE_CCM_BIT]);
		end
	end

	// ----------------------------------------------------------------
	// reference dac: ramp value, then servo steps
	// ----------------------------------------------------------------
	logic [15:0] servo_cnt_q;
	logic servo_en;
	assign servo_en = permit_q && switching_mode_config[MODE_SERVO_EN_BIT];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			servo_cnt_q <= COUNT_RST;
		end else if (!servo_en || servo_cnt_q == SERVO_TICKS) begin
			servo_cnt_q <= COUNT_RST;
		end else if (tb_tick) begin
			servo_cnt_q <= servo_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_dac_code <= TARGET_RST;
		end else begin
			case (state_q)
				PSS_RAMP: begin
					if (ramp_skip) begin
						ref_dac_code <= vout_set_point;
					end else if (step_done) begin
						ref_dac_code <= quo_q[15:0];
					end
				end
				PSS_ON: begin
					if (!permit_q && ref_dac_code != vout_set_point && !servo_en) begin
						ref_dac_code <= vout_set_point;
					end else if (servo_en && servo_cnt_q == SERVO_TICKS) begin
						// one lsb toward agreement, hold when equal
						if (adc_reading < vout_set_point && ref_dac_code != 16'hFFFF) begin
							ref_dac_code <= ref_dac_code + 16'h0001;
						end else if (adc_reading > vout_set_point && ref_dac_code != 16'h0000) begin
							ref_dac_code <= ref_dac_code - 16'h0001;
						end
					end
				end
				default: begin
					ref_dac_code <= TARGET_RST;
				end
			endcase
		end
	end

	// step size reported per range setting
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			servo_step_nv <= DAC_LSB_HI_NV;
			servo_active <= 1'b0;
		end else begin
			servo_step_nv <= voltage_range_high ? DAC_LSB_HI_NV : DAC_LSB_LO_NV;
			servo_active <= servo_en;
		end
	end

	// ----------------------------------------------------------------
	// general-purpose output with deglitched comparator
	// ----------------------------------------------------------------
	logic [15:0] flt_cnt_q;
	logic uvu_flt_q;

	// new level must hold for the whole filter time
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flt_cnt_q <= COUNT_RST;
			uvu_flt_q <= 1'b1;
		end else if (uvu_s == uvu_flt_q) begin
			flt_cnt_q <= COUNT_RST;
		end else if (flt_cnt_q == 16'(UV_FILTER - 1)) begin
			uvu_flt_q <= uvu_s;
			flt_cnt_q <= COUNT_RST;
		end else begin
			flt_cnt_q <= flt_cnt_q + 16'h0001;
		end
	end

	// released once above the limit, source chosen by select
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gpio_oe <= 1'b1;
		end else begin
			gpio_oe <= unfiltered_uv_propagate_select ? uvu_flt_q : uvf_s;
		end
	end
	assign gpio_o = 1'b0;

endmodule

`default_nettype wire

//--- verif/pss_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// peer controller on the shared lines
// ----------------------------------------
module pss_peer_model #(
	parameter int PER = 36,
	parameter int LOW = 9
) (
	input wire logic clk,
	input wire logic ready,
	input wire logic tb_i,
	output logic run_oe,
	output logic tb_oe
);
	int cnt_q = 0;
	logic tb_q = 1'b1;
	// pull run low until this peer is ready too
	assign run_oe = !ready;
	// own time base, low phase only once ready
	assign tb_oe = ready && (cnt_q < LOW);
	// an earlier fall on the line restarts the period, so the fastest wins
	always_ff @(posedge clk) begin
		tb_q <= tb_i;
		if (tb_q && !tb_i) begin
			cnt_q <= 1;
		end else begin
			cnt_q <= (cnt_q >= PER - 1) ? 0 : cnt_q + 1;
		end
	end
endmodule
`default_nettype wire

//--- verif/pss_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// sequencer port checks
// ----------------------------------------
module pss_chk
	import pss_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic init_done,
	input wire logic vin_above_on,
	input wire logic run_line_oe,
	input wire logic [7:0] switching_mode_config,
	input wire logic voltage_range_high,
	input wire logic uv_unfiltered,
	input wire logic uv_filtered,
	input wire logic reverse_current,
	input wire logic unfiltered_uv_propagate_select,
	input wire logic [15:0] vout_set_point,
	input wire logic [15:0] ref_dac_code,
	input wire logic [20:0] servo_step_nv,
	input wire logic dcm_forced,
	input wire logic ccm_active,
	input wire logic bottom_gate_off,
	input wire logic servo_active,
	input wire logic gpio_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// start-up, ramp and mode hand-over
	a_run_held_low: assert property ((!init_done || !vin_above_on)[*5] |-> run_line_oe)
		else $error("run line released while not ready");
	a_ramp_rises: assert property (dcm_forced && !run_line_oe && ref_dac_code != $past(ref_dac_code)
		|-> ref_dac_code > $past(ref_dac_code) && ref_dac_code <= vout_set_point)
		else $error("ramp target not rising to set point");
	a_dcm_exclusive: assert property (dcm_forced |-> !ccm_active && !servo_active)
		else $error("continuous or servo while forced");
	a_mode_at_permit: assert property ($fell(dcm_forced)
		|-> ccm_active == switching_mode_config[MODE_CCM_BIT])
		else $error("wrong mode at permission");
	a_gate_reverse: assert property ((reverse_current && !ccm_active)[*4] |-> bottom_gate_off)
		else $error("bottom gate left on with reverse current");
	// servo stepping
	a_servo_gated: assert property (servo_active
		|-> switching_mode_config[MODE_SERVO_EN_BIT] && !dcm_forced)
		else $error("servo running without enable");
	a_servo_one_lsb: assert property (servo_active && $past(servo_active)
		&& ref_dac_code != $past(ref_dac_code)
		|-> ref_dac_code == $past(ref_dac_code) + 16'h0001
		|| ref_dac_code == $past(ref_dac_code) - 16'h0001)
		else $error("servo step not one code");
	a_step_size: assert property ($stable(voltage_range_high)[*5]
		|-> servo_step_nv == (voltage_range_high ? DAC_LSB_HI_NV : DAC_LSB_LO_NV))
		else $error("step size does not match range");
	// general-purpose output
	a_gpio_deglitch: assert property (unfiltered_uv_propagate_select
		&& gpio_oe != $past(gpio_oe)
		|-> $past(uv_unfiltered, 4) == gpio_oe && $past(uv_unfiltered, 8) == gpio_oe)
		else $error("gpio moved on a short glitch");
	a_gpio_filtered: assert property ((!unfiltered_uv_propagate_select
		&& $stable(uv_filtered))[*6] |-> gpio_oe == uv_filtered)
		else $error("gpio not following filtered flag");
endmodule

bind pss_power_up_soft_start_servo pss_chk pss_chk_i (.clk, .rst, .init_done, .vin_above_on,
	.run_line_oe, .switching_mode_config, .voltage_range_high, .uv_unfiltered, .uv_filtered,
	.reverse_current, .unfiltered_uv_propagate_select, .vout_set_point, .ref_dac_code,
	.servo_step_nv, .dcm_forced, .ccm_active, .bottom_gate_off, .servo_active, .gpio_oe);
`default_nettype wire

//--- verif/test_power_up_soft_start_servo.sv
`timescale 1ns/1ps
`default_nettype none
module test_power_up_soft_start_servo;
	import pss_pkg::*;
	localparam int TK = 36;
	logic clk, rst, init_done, vin_ok, peer_rdy, resp, vrh, uvu, uvf, oc, rev, sel;
	logic run_oe, tb_oe, p_run, p_tb, dcm, ccm, bgo, srv, gpio_oe;
	logic [15:0] dly, rise, lim, setp, adc, dac;
	logic [7:0] mode;
	logic [20:0] step;
	int fail_count = 0;
	int num_checks = 0;
	int seed = 90952;
	int t;
	wire run_w = !(run_oe || p_run);
	wire tb_w = !(tb_oe || p_tb);

	pss_power_up_soft_start_servo #(.TB_PERIOD(40), .TB_LOW(10), .UV_FILTER(8))
	pss_power_up_soft_start_servo_i (.clk, .rst, .init_done, .vin_above_on(vin_ok),
		.run_line_i(run_w), .run_line_o(), .run_line_oe(run_oe), .share_clk_i(tb_w),
		.share_clk_o(), .share_clk_oe(tb_oe), .turn_on_delay(dly), .ramp_rise_time(rise),
		.max_turn_on_time_limit(lim), .max_turn_on_time_response(resp),
		.vout_set_point(setp), .switching_mode_config(mode), .voltage_range_high(vrh),
		.uv_unfiltered(uvu), .uv_filtered(uvf), .output_overcurrent_fault(oc),
		.reverse_current(rev), .unfiltered_uv_propagate_select(sel), .adc_reading(adc),
		.ref_dac_code(dac), .servo_step_nv(step), .dcm_forced(dcm), .ccm_active(ccm),
		.bottom_gate_off(bgo), .servo_active(srv), .gpio_o(), .gpio_oe);
	pss_peer_model #(.PER(TK), .LOW(9)) pss_peer_model_i (.clk, .ready(peer_rdy),
		.tb_i(tb_w), .run_oe(p_run), .tb_oe(p_tb));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, exp, got);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	function automatic int exp_steps(int r);
		if (r * 100 < 250) return 1;
		return (r > 13000) ? 13000 : r;
	endfunction
	// reset with a new configuration
	task automatic start(logic [15:0] d, r, l, logic [7:0] m, logic s);
		rst <= 1'b1;
		dly <= d;
		rise <= r;
		lim <= l;
		mode <= m;
		sel <= s;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic wait_dac(int lim_c);
		logic [15:0] v;
		v = dac;
		t = 0;
		while (dac === v && t < lim_c) begin
			@(posedge clk);
			t++;
		end
	endtask
	task automatic wait_dcm(int lim_c);
		t = 0;
		while (dcm !== 1'b0 && t < lim_c) begin
			@(posedge clk);
			t++;
		end
	endtask
	// time the delay after release, then count ramp steps
	task automatic ramp(int n);
		int k;
		t = 0;
		while (run_w !== 1'b1 && t < 500) begin
			@(posedge clk);
			t++;
		end
		wait_dac(2000);
		chk("delay", (n == 1) ? (t > (dly - 1) * TK && t <= dly * TK + 10)
			: (t >= dly * TK + 16 && t <= dly * TK + 130), 1);
		k = 1;
		while (dac !== setp && k < 20) begin
			wait_dac(500);
			k++;
		end
		chk("steps", k, n);
		chk("final", dac, setp);
	endtask
	task automatic per();
		time t0;
		@(posedge tb_w);
		t0 = $time;
		@(posedge tb_w);
		t = int'(($time - t0) / 4);
	endtask

	// clock, random reverse current and watchdog
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial forever begin
		repeat (8) @(posedge clk);
		rev <= 1'($random(seed));
	end
	initial begin
		#380000;
		fail_count++;
		report_and_stop;
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		{rst, init_done, vin_ok, peer_rdy, resp, vrh, uvu, uvf, oc, rev, sel} = 11'h401;
		{dly, rise, lim, adc, mode} = '0;
		setp = 16'h0800;
		@(posedge clk);
		peer_rdy <= 1'b1;
		vin_ok <= 1'b1;
		start(3, 3, 0, 8'h01, 1'b0);
		repeat (20) @(posedge clk);
		chk("own_hold", run_oe, 1);
		uvf <= 1'b1;
		repeat (12) @(posedge clk);
		chk("gpio_filt", gpio_oe, 1);
		uvf <= 1'b0;
		peer_rdy <= 1'b0;
		init_done <= 1'b1;
		repeat (20) @(posedge clk);
		chk("own_free", run_oe, 0);
		chk("peer_hold", run_w, 0);
		chk("no_ramp", dac, 0);
		peer_rdy <= 1'b1;
		ramp(3);
		per();
		chk("tick", t >= TK - 2 && t <= TK + 2, 1);
		wait_dcm(20);
		chk("ccm", ccm, 1);
		$display("test start_gate done");
		// random delays, rises, ranges and modes, two short rises first
		for (int i = 0; i < 4; i++) begin
			vrh <= 1'($random(seed));
			setp <= 16'h0400 + 16'({$random(seed)} % 3072);
			start(16'(3 + {$random(seed)} % 4), (i < 2) ? 16'(i + 1) : 16'(3 + {$random(seed)} % 8),
				0, 8'($random(seed)) & 8'hBF, 1'b0);
			ramp(exp_steps(rise));
			wait_dcm(20);
			chk("mode", ccm, mode[0]);
			chk("lsb", step, vrh ? DAC_LSB_HI_NV : DAC_LSB_LO_NV);
			chk("no_servo", srv, 0);
		end
		$display("test random_ramps done");
		// overcurrent holds permission, raw undervoltage drives the output
		oc <= 1'b1;
		start(3, 3, 0, 8'h00, 1'b1);
		ramp(3);
		uvu <= 1'b1;
		repeat (4) @(posedge clk);
		uvu <= 1'b0;
		repeat (30) @(posedge clk);
		chk("glitch", gpio_oe, 0);
		uvu <= 1'b1;
		repeat (30) @(posedge clk);
		chk("uv_seen", gpio_oe, 1);
		chk("oc_hold", dcm, 1);
		oc <= 1'b0;
		uvu <= 1'b0;
		wait_dcm(20);
		chk("oc_clear", dcm, 0);
		$display("test fault_gpio done");
		// nonzero turn-on limit delays permission
		resp <= 1'b1;
		start(3, 3, 20, 8'h00, 1'b0);
		ramp(3);
		wait_dcm(1500);
		chk("limit", t >= 14 * TK && t <= 20 * TK, 1);
		// ignore response: overcurrent alone does not hold permission after the limit
		resp <= 1'b0;
		oc <= 1'b1;
		start(3, 3, 20, 8'h00, 1'b0);
		ramp(3);
		wait_dcm(1500);
		chk("limit_ign", t >= 14 * TK && t <= 20 * TK, 1);
		oc <= 1'b0;
		$display("test limit done");
		// servo steps the dac up while the reading is below the set point, one code per interval
		setp <= 16'h0800;
		adc <= 16'h07FD;
		start(3, 3, 0, 8'h41, 1'b0);
		ramp(3);
		wait_dcm(20);
		wait_dac(34000);
		chk("servo_on", srv, 1);
		chk("servo_up", dac, setp + 16'h0001);
		wait_dac(34000);
		chk("interval", t >= 895 * TK && t <= 905 * TK, 1);
		chk("servo_up2", dac, setp + 16'h0002);
		$display("test servo done");
		report_and_stop;
	end
endmodule
`default_nettype wire
